// File: ots_pkg.sv
// package: constants for the otg status and vbus control block
package ots_pkg;
  // ****************************************
  // reset and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 60;
  localparam logic [7:0] POR_CYCLES = 8'h10;
  // ****************************************
  // clock plan: divide ratios from the 480 mhz bit clock
  // ****************************************
  localparam int unsigned HS_MHZ = 480;
  localparam int unsigned FS_MHZ = 12;
  localparam int unsigned IF_DIV = HS_MHZ / CLK_MHZ;
  localparam int unsigned FS_DIV = CLK_MHZ / FS_MHZ;
  localparam int unsigned LS_DIV = 40;
  // ****************************************
  // status command layout (vbus state in [1:0])
  // ****************************************
  localparam int unsigned ST_VBUS_LO = 0;
  localparam int unsigned ST_SESS_END = 2;
  localparam int unsigned ST_ID_GROUNDED_FLAG = 3;
  localparam int unsigned ST_FAULT = 4;
  localparam logic [1:0] VBUS_VALID = 2'h3;
  localparam logic [1:0] VBUS_SESS = 2'h2;
  localparam logic [1:0] VBUS_ABOVE_END = 2'h1;
  localparam logic [1:0] VBUS_LOW = 2'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// File: ots_top.sv
// top: otg status reporting, vbus control and clock dividers
`timescale 1ns/1ns
// What this block does
// RULE1: id reported only when sense enabled
// RULE2: id change triggers status command
// RULE3: b plug reports id grounded one
// RULE4: a plug reports id grounded zero
// RULE5: link discharges, waits session end, then charges
// RULE6: link sends reset command after clock starts
// RULE7: internal power-on reset holds all logic; the clock dividers and synchronisers run through it
// RULE8: link drives zero on idle bus
// RULE9: chip select high tristates data outputs
// RULE10: weak pull-downs on data pins
// RULE11: link configures external fault select, polarity
// RULE12: fault events sent as status commands
// RULE13: derive 60, 12, 1.5 mhz enables
// RULE14: link ignores vbus valid at power-up
// RULE15: host clears external drive on bad vbus; the link model only raises vbus_bad
// RULE16: synchronise id, comparators, fault before compare
module ots_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // analog and pin inputs
  input wire logic id_level,
  input wire logic cmp_vbus_valid,
  input wire logic cmp_sess_valid,
  input wire logic cmp_sess_end,
  input wire logic fault_in,
  input wire logic chip_select_n,
  // control bits from the register set
  input wire logic id_sense_enable,
  input wire logic vbus_discharge_enable,
  input wire logic vbus_charge_enable,
  input wire logic external_fault_select,
  input wire logic fault_polarity_invert,
  input wire logic fault_passthrough,
  input wire logic external_vbus_drive,
  input wire logic status_irq_mode,
  // status toward the ulpi controller
  output logic status_cmd_valid,
  output logic [7:0] status_cmd,
  input wire logic status_cmd_taken,
  output logic status_irq,
  output logic id_grounded_flag,
  output logic session_end_flag,
  output logic por_active,
  // data pin control
  output logic data_pulldown_en,
  output logic data_oe_n,
  // analog actuators
  output logic discharge_on,
  output logic charge_on,
  output logic psw_n_oe_n,
  // rate enables
  output logic hs_tick,
  output logic if_tick,
  output logic fs_tick,
  output logic ls_tick
);
  // ****************************************
  // internal power-on reset
  // ****************************************
  logic [7:0] por_cnt_r;
  logic por_r;
  // por_active holds while a counter counts up to POR_CYCLES after reset; no external pin needed
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      por_cnt_r <= 8'h00;
      por_r <= 1'b1;
    end else if (por_cnt_r != ots_pkg::POR_CYCLES) begin
      por_cnt_r <= por_cnt_r + 8'h01;
      por_r <= 1'b1; // see RULE7
    end else begin
      por_r <= 1'b0;
    end
  end
  assign por_active = por_r;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [4:0] raw_in;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  assign raw_in = {fault_in, cmp_sess_end, cmp_sess_valid, cmp_vbus_valid, id_level};
  // two flops each; only sync2 feeds the status logic
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= raw_in; // see RULE16
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // status word and change detection
  // ****************************************
  logic id_grounded_flag_s;
  logic fault_s;
  logic [7:0] cur_status;
  logic [7:0] last_status_r;
  logic pend_r;
  // id high means b-plug, which must report the grounded flag as one
  assign id_grounded_flag_s = id_sense_enable & sync2_r[0];
  // fault is qualified by both enables, select and passthrough; polarity invert only flips it
  assign fault_s = external_fault_select & fault_passthrough & (sync2_r[4] ^ fault_polarity_invert);
  always_comb begin
    cur_status = ots_pkg::STATUS_RESET;
    if (sync2_r[1])
      cur_status[1:0] = ots_pkg::VBUS_VALID;
    else if (sync2_r[2])
      cur_status[1:0] = ots_pkg::VBUS_SESS;
    else if (!sync2_r[3])
      cur_status[1:0] = ots_pkg::VBUS_ABOVE_END;
    else
      cur_status[1:0] = ots_pkg::VBUS_LOW;
    // external fault forces the vbus state off valid
    if (fault_s)
      cur_status[1:0] = ots_pkg::VBUS_LOW; // see RULE12
    cur_status[ots_pkg::ST_SESS_END] = sync2_r[3];
    cur_status[ots_pkg::ST_ID_GROUNDED_FLAG] = id_grounded_flag_s; // see RULE3 RULE4
    cur_status[ots_pkg::ST_FAULT] = fault_s;
  end
  // keep id field frozen while sensing is off so no change is seen
  logic [7:0] cmp_status;
  always_comb begin
    cmp_status = cur_status;
    if (!id_sense_enable)
      cmp_status[ots_pkg::ST_ID_GROUNDED_FLAG] = last_status_r[ots_pkg::ST_ID_GROUNDED_FLAG]; // see RULE1
  end

  // latch a change and present it until taken; new change wins over take
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last_status_r <= ots_pkg::STATUS_RESET;
      pend_r <= 1'b0;
    end else if (por_r) begin
      last_status_r <= ots_pkg::STATUS_RESET;
      pend_r <= 1'b0;
    end else if (cmp_status != last_status_r) begin
      last_status_r <= cmp_status; // see RULE2
      pend_r <= 1'b1;
    end else if (status_cmd_taken) begin
      pend_r <= 1'b0;
    end
  end

  // outputs: status command or interrupt, by mode
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_cmd_valid <= 1'b0;
      status_cmd <= ots_pkg::STATUS_RESET;
      status_irq <= 1'b0;
      id_grounded_flag <= 1'b0;
      session_end_flag <= 1'b0;
    end else begin
      status_cmd_valid <= pend_r & ~status_irq_mode & ~chip_select_n; // see RULE2 RULE12
      status_irq <= pend_r & status_irq_mode;
      status_cmd <= last_status_r;
      id_grounded_flag <= last_status_r[ots_pkg::ST_ID_GROUNDED_FLAG];
      session_end_flag <= last_status_r[ots_pkg::ST_SESS_END];
    end
  end

  // ****************************************
  // pins and actuators
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_oe_n <= 1'b1;
      data_pulldown_en <= 1'b1;
      discharge_on <= 1'b0;
      charge_on <= 1'b0;
      psw_n_oe_n <= 1'b1;
    end else begin
      data_oe_n <= chip_select_n | por_r; // see RULE9
      data_pulldown_en <= 1'b1; // see RULE10
      // sequencing is the link's job; charge wins if both are set
      discharge_on <= vbus_discharge_enable & ~vbus_charge_enable & ~por_r;
      charge_on <= vbus_charge_enable & ~por_r;
      // open drain: enable low pulls the pin low
      psw_n_oe_n <= ~(external_vbus_drive & ~por_r);
    end
  end

  // ****************************************
  // clock plan as rate enables off the 480 mhz reference
  // ****************************************
  logic [2:0] if_cnt_r;
  logic [3:0] fs_cnt_r;
  logic [5:0] ls_cnt_r;
  // core_clk stands for the bit clock; counts give the lower rates
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      if_cnt_r <= 3'h0;
      fs_cnt_r <= 4'h0;
      ls_cnt_r <= 6'h00;
      hs_tick <= 1'b0;
      if_tick <= 1'b0;
      fs_tick <= 1'b0;
      ls_tick <= 1'b0;
    end else begin
      hs_tick <= 1'b1; // see RULE13
      if_tick <= (if_cnt_r == 3'(ots_pkg::IF_DIV - 1));
      if_cnt_r <= (if_cnt_r == 3'(ots_pkg::IF_DIV - 1)) ? 3'h0 : if_cnt_r + 3'h1;
      fs_tick <= 1'b0;
      ls_tick <= 1'b0;
      if (if_cnt_r == 3'(ots_pkg::IF_DIV - 1)) begin
        fs_cnt_r <= (fs_cnt_r == 4'(ots_pkg::FS_DIV - 1)) ? 4'h0 : fs_cnt_r + 4'h1;
        ls_cnt_r <= (ls_cnt_r == 6'(ots_pkg::LS_DIV - 1)) ? 6'h00 : ls_cnt_r + 6'h01;
        fs_tick <= (fs_cnt_r == 4'(ots_pkg::FS_DIV - 1)); // see RULE13
        ls_tick <= (ls_cnt_r == 6'(ots_pkg::LS_DIV - 1));
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_id_off;
    @(posedge core_clk) disable iff (reset)
      !id_sense_enable && $stable(id_sense_enable) |=> $stable(last_status_r[ots_pkg::ST_ID_GROUNDED_FLAG]);
  endproperty
  a_id_off: assert property (p_id_off) else $error("id changed while sensing off"); // see RULE1
  property p_change_pend;
    @(posedge core_clk) disable iff (reset)
      !por_r && cmp_status != last_status_r |=> pend_r;
  endproperty
  a_change_pend: assert property (p_change_pend) else $error("change not pending"); // see RULE2
  property p_cmd_out;
    @(posedge core_clk) disable iff (reset)
      pend_r && !status_irq_mode && !chip_select_n |=> status_cmd_valid;
  endproperty
  a_cmd_out: assert property (p_cmd_out) else $error("status command missing"); // see RULE12
  property p_idgnd;
    @(posedge core_clk) disable iff (reset)
      !por_r && id_sense_enable && sync2_r[0] ##1 id_sense_enable |-> ##1 id_grounded_flag;
  endproperty
  a_idgnd: assert property (p_idgnd) else $error("grounded flag not set"); // see RULE3
  property p_idhi;
    @(posedge core_clk) disable iff (reset)
      !por_r && id_sense_enable && !sync2_r[0] ##1 id_sense_enable |-> ##1 !id_grounded_flag;
  endproperty
  a_idhi: assert property (p_idhi) else $error("grounded flag not clear"); // see RULE4
  property p_por;
    @(posedge core_clk) $fell(reset) |-> por_active [*8];
  endproperty
  a_por: assert property (p_por) else $error("power-on reset too short"); // see RULE7
  property p_cs;
    @(posedge core_clk) disable iff (reset) chip_select_n |=> data_oe_n;
  endproperty
  a_cs: assert property (p_cs) else $error("data driven while deselected"); // see RULE9
  property p_pd;
    @(posedge core_clk) disable iff (reset) data_pulldown_en;
  endproperty
  a_pd: assert property (p_pd) else $error("pull-downs off"); // see RULE10
  property p_fs;
    @(posedge core_clk) disable iff (reset) $rose(fs_tick) |=> !fs_tick [*8];
  endproperty
  a_fs: assert property (p_fs) else $error("full speed tick too close"); // see RULE13
  property p_sync;
    @(posedge core_clk) disable iff (reset) 1'b1 |=> sync2_r == $past(sync1_r);
  endproperty
  a_sync: assert property (p_sync) else $error("sync stage broken"); // see RULE16
  c_cmd: cover property (@(posedge core_clk) status_cmd_valid && status_cmd_taken);
  c_irq: cover property (@(posedge core_clk) status_irq);
  c_fault: cover property (@(posedge core_clk) status_cmd[ots_pkg::ST_FAULT]);
endmodule

// File: ots_link_model.sv
// link controller model: takes status words and follows the reported role
`timescale 1ns/1ns
module ots_link_model #(
  // reset command byte sent once after the clock starts; value is arbitrary
  parameter logic [7:0] RESET_CMD = 8'h5A
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // status path from the block
  input wire logic status_cmd_valid,
  input wire logic [7:0] status_cmd,
  output logic status_cmd_taken,
  // model control and view
  input wire logic [3:0] ack_delay,
  output logic [7:0] last_status,
  output logic host_role,
  // data bus as driven by the link, and its power verdict
  output logic [7:0] link_data,
  output logic vbus_bad
);
  // ****************************************
  // start-up command and idle bus
  // ****************************************
  logic sent_r;
  logic seen_r;
  // one reset command once the clock runs, then the bus idles at zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sent_r <= 1'b0;
      link_data <= 8'h00;
    end else begin
      sent_r <= 1'b1;
      link_data <= sent_r ? 8'h00 : RESET_CMD;
    end
  end
  // ****************************************
  // status intake
  // ****************************************
  logic [3:0] wait_r;
  logic [1:0] hold_r;
  // hold off two edges after a take, since valid only drops two edges after the take
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_r <= 4'h0;
      hold_r <= 2'h0;
      status_cmd_taken <= 1'b0;
      last_status <= 8'h00;
      host_role <= 1'b0;
      seen_r <= 1'b0;
      vbus_bad <= 1'b0;
    end else begin
      status_cmd_taken <= 1'b0;
      if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1;
      end else if (sent_r && status_cmd_valid && !status_cmd_taken) begin
        if (wait_r >= ack_delay) begin
          status_cmd_taken <= 1'b1;
          last_status <= status_cmd;
          host_role <= ~status_cmd[ots_pkg::ST_ID_GROUNDED_FLAG];
          // the power-up word is ignored; afterwards a host needs valid vbus
          seen_r <= 1'b1;
          vbus_bad <= seen_r & ~status_cmd[ots_pkg::ST_ID_GROUNDED_FLAG] & (status_cmd[1:0] != ots_pkg::VBUS_VALID);
          wait_r <= 4'h0;
          hold_r <= 2'h2;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule

// File: tb_otg_status_and_vbus_control.sv
// testbench for the otg status and vbus control block
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t mismatch at line %0d", $time, `__LINE__); end end
module tb_otg_status_and_vbus_control;
  // ****************************************
  // signals and instances
  // ****************************************
  logic core_clk, reset, id_level, cmp_vbus_valid, cmp_sess_valid, cmp_sess_end, fault_in;
  logic chip_select_n, id_sense_enable, vbus_discharge_enable, vbus_charge_enable;
  logic external_fault_select, fault_polarity_invert, fault_passthrough, external_vbus_drive;
  logic status_irq_mode, status_cmd_valid, status_cmd_taken, status_irq, id_grounded_flag;
  logic session_end_flag, por_active, data_pulldown_en, data_oe_n, discharge_on, charge_on;
  logic psw_n_oe_n, hs_tick, if_tick, fs_tick, ls_tick, host_role;
  logic [7:0] status_cmd, last_status, link_data;
  logic vbus_bad;
  logic [3:0] ack_delay;
  int error_cnt = 0;
  int n_tests = 0;
  ots_top ots_top_i (.*);
  ots_link_model ots_link_model_i (.*);
  // clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  // inputs always move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // bounded wait for the link to take a word, then judge it
  task automatic expect_cmd(input logic [7:0] exp);
    int k;
    k = 0;
    while (status_cmd_taken !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    `CHK(k < 20, 1'b1)
    step(3);
    `CHK(last_status, exp)
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_por();
    step(1);
    `CHK(por_active, 1'b1)
    `CHK(data_oe_n, 1'b1)
    `CHK(data_pulldown_en, 1'b1)
    step(25);
    `CHK(por_active, 1'b0)
    `CHK(data_pulldown_en, 1'b1)
    `CHK(data_oe_n, 1'b0)
    // first word after power-up: vbus above session end, id field still clear
    `CHK(last_status, 8'h01)
    `CHK(host_role, 1'b1)
    `CHK(vbus_bad, 1'b0)
    `CHK(link_data, 8'h00)
  endtask
  task automatic t_id();
    // b-plug attached while sensing is still off
    id_level = 1'b1;
    step(8);
    `CHK(status_cmd_valid, 1'b0)
    `CHK(id_grounded_flag, 1'b0)
    id_sense_enable = 1'b1;
    expect_cmd(8'h09);
    `CHK(id_grounded_flag, 1'b1)
    `CHK(host_role, 1'b0)
  endtask
  // pending word must wait behind a deselected bus, slow link afterwards
  task automatic t_cs();
    chip_select_n = 1'b1;
    step(2);
    `CHK(data_oe_n, 1'b1)
    cmp_sess_end = 1'b1;
    step(8);
    `CHK(status_cmd_valid, 1'b0)
    ack_delay = 4'h5;
    chip_select_n = 1'b0;
    expect_cmd(8'h0C);
    `CHK(session_end_flag, 1'b1)
    ack_delay = 4'h0;
  endtask
  task automatic t_srp();
    vbus_discharge_enable = 1'b1;
    step(3);
    `CHK(discharge_on, 1'b1)
    `CHK(charge_on, 1'b0)
    if (session_end_flag === 1'b1) begin
      vbus_discharge_enable = 1'b0;
      vbus_charge_enable = 1'b1;
    end
    step(3);
    `CHK(charge_on, 1'b1)
    `CHK(discharge_on, 1'b0)
    cmp_sess_end = 1'b0;
    cmp_sess_valid = 1'b1;
    expect_cmd(8'h0A);
    vbus_charge_enable = 1'b0;
  endtask
  task automatic t_fault();
    external_fault_select = 1'b1;
    fault_in = 1'b1;
    step(8);
    `CHK(status_cmd_valid, 1'b0)
    fault_passthrough = 1'b1;
    expect_cmd(8'h18);
    fault_polarity_invert = 1'b1;
    expect_cmd(8'h0A);
    external_vbus_drive = 1'b1;
    step(3);
    `CHK(psw_n_oe_n, 1'b0)
    external_vbus_drive = 1'b0;
  endtask
  // whole periods, so counts do not depend on divider phase
  task automatic t_ticks();
    int h, i, f, l;
    h = 0; i = 0; f = 0; l = 0;
    repeat (320) begin
      step(1);
      h += hs_tick; i += if_tick; f += fs_tick; l += ls_tick;
    end
    `CHK(h, 320)
    `CHK(i, 40)
    `CHK(f, 8)
    `CHK(l, 1)
  endtask
  // left last: the irq stays pending with no way to clear it here
  task automatic t_irq();
    status_irq_mode = 1'b1;
    id_level = 1'b0;
    step(2);
    `CHK(status_irq, 1'b0)
    step(4);
    `CHK(status_irq, 1'b1)
    `CHK(status_cmd_valid, 1'b0)
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {reset, id_level} = 2'h3;
    {cmp_vbus_valid, cmp_sess_valid, cmp_sess_end, fault_in, chip_select_n} = 5'h00;
    {id_sense_enable, vbus_discharge_enable, vbus_charge_enable, external_fault_select} = 4'h0;
    {fault_polarity_invert, fault_passthrough, external_vbus_drive, status_irq_mode} = 4'h0;
    ack_delay = 4'h0;
    step(5);
    reset = 1'b0;
    t_por();
    t_id();
    t_cs();
    t_srp();
    t_fault();
    t_ticks();
    t_irq();
    give_verdict();
  end
  initial begin
    #(8 * 2000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
